/* hw/health_log_pkg.sv */
// Constants for the health and usage statistics page.
// Assumes a single 50 MHz controller clock and a synchronous reset.
package health_log_pkg;

   // ----------------------------------------
   // Page layout
   // ----------------------------------------
   localparam int PAGE_BYTES = 512;
   localparam logic [8:0] OFS_CRIT = 9'h000;
   localparam logic [8:0] OFS_TEMP_LO = 9'h001;
   localparam logic [8:0] OFS_TEMP_HI = 9'h002;
   localparam logic [8:0] OFS_SPARE = 9'h003;
   localparam logic [8:0] OFS_SPARE_THR = 9'h004;
   localparam logic [8:0] OFS_LIFE = 9'h005;
   localparam logic [8:0] OFS_CTR_BASE = 9'h020;
   localparam logic [8:0] OFS_CTR_END = 9'h0BF;
   localparam int NUM_FIELDS = 10;

   // ----------------------------------------
   // Critical warning bit positions
   // ----------------------------------------
   localparam int CRIT_SPARE = 0;
   localparam int CRIT_TEMP = 1;
   localparam int CRIT_DEGRADED = 2;
   localparam int CRIT_READ_ONLY = 3;
   localparam int CRIT_BACKUP = 4;

   // ----------------------------------------
   // Counter slots, in page order after the two data unit fields
   // ----------------------------------------
   localparam int NUM_CTRS = 8;
   localparam int CTR_RD_CMD = 0;
   localparam int CTR_WR_CMD = 1;
   localparam int CTR_BUSY_MIN = 2;
   localparam int CTR_POWER_CYC = 3;
   localparam int CTR_POWER_HRS = 4;
   localparam int CTR_UNSAFE = 5;
   localparam int CTR_INTEGRITY = 6;
   localparam int CTR_ERR_LOG = 7;

   // ----------------------------------------
   // Values and limits
   // ----------------------------------------
   localparam logic [7:0] LIFE_SAT_LIMIT = 8'hFE;
   localparam logic [7:0] LIFE_SAT = 8'hFF;
   localparam logic [7:0] SPARE_MAX = 8'h64;
   localparam logic [9:0] UNITS_PER_KILO = 10'h3E8;
   localparam logic [3:0] UNIT_SHIFT = 4'h9;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   localparam longint CLK_PERIOD_NS = 20;
   localparam longint SECOND_NS = 1000000000;
   localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam logic [5:0] SECS_PER_MIN = 6'h3C;
   localparam logic [11:0] SECS_PER_HOUR = 12'hE10;

endpackage : health_log_pkg

/* hw/unit_kilo_counter.sv */
// Accumulator of 512-byte data units, reported in thousands, rounded up.
// Assumes add pulses come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module unit_kilo_counter
   import health_log_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic add_i,
   input wire logic [31:0] units_i,
   output logic [127:0] kilo_o
);

   logic [31:0] pend_reg;
   logic [9:0] rem_reg;
   logic [127:0] kilo_reg;
   logic [31:0] room;
   logic drain_full;

   // Up to one thousand is retired per cycle; large commands drain over cycles
   assign room = 32'(UNITS_PER_KILO) - {22'h0, rem_reg};
   assign drain_full = pend_reg >= room;

   // Pending units waiting to be folded in
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         pend_reg <= 32'h00000000;
      else
         pend_reg <= (drain_full ? pend_reg - room : 32'h00000000)
                     + (add_i ? units_i : 32'h00000000);
   end

   // Partial thousand and whole thousands, wrapping at full width
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         rem_reg <= 10'h000;
         kilo_reg <= 128'h0;
      end
      else if (drain_full)
      begin
         rem_reg <= 10'h000;
         kilo_reg <= kilo_reg + 128'h1;
      end
      else
         rem_reg <= rem_reg + pend_reg[9:0];
   end

   // Any partial thousand counts as a whole one
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         kilo_o <= 128'h0;
      else
         kilo_o <= kilo_reg + {127'h0, rem_reg != 10'h000};
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_drain;
      drain_full;
   endsequence

   a_rem_in_range: assert property (rem_reg < UNITS_PER_KILO)
      else $error("partial thousand out of range");
   a_kilo_step: assert property (s_drain |=> kilo_reg == $past(kilo_reg) + 128'h1)
      else $error("thousand not retired");
   a_round_up: assert property (rem_reg != 10'h000 |=> kilo_o == $past(kilo_reg) + 128'h1)
      else $error("partial thousand not rounded up");

endmodule : unit_kilo_counter
`default_nettype wire

/* hw/health_log.sv */
// Health and usage statistics keeper with a 512-byte page read port.
// Assumes all event pulses and levels come from controller logic on sys_clk_i.
`timescale 1ns/100ps
`default_nettype none
module health_log
   import health_log_pkg::*;
#(
   parameter int SEC_CYCLES_P = SEC_CYCLES
)
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] temp_kelvin_i,
   input wire logic [15:0] temp_threshold_i,
   input wire logic [7:0] spare_pct_i,
   input wire logic [7:0] spare_threshold_i,
   input wire logic [15:0] life_estimate_i,
   input wire logic degraded_i,
   input wire logic read_only_i,
   input wire logic backup_failed_i,
   input wire logic sleep_i,
   input wire logic rd_done_i,
   input wire logic [15:0] rd_blocks_i,
   input wire logic wr_done_i,
   input wire logic [15:0] wr_blocks_i,
   input wire logic wr_uncorr_i,
   input wire logic [3:0] lba_shift_i,
   input wire logic io_submit_i,
   input wire logic io_complete_i,
   input wire logic power_up_i,
   input wire logic power_loss_i,
   input wire logic [1:0] host_shutdown_notice_field_i,
   input wire logic integrity_err_i,
   input wire logic err_log_entry_i,
   input wire logic page_rd_i,
   input wire logic [8:0] page_addr_i,
   output logic [7:0] page_data_o,
   output logic page_valid_o,
   output logic temp_event_o,
   output logic spare_event_o,
   output logic [7:0] crit_warning_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] crit_reg;
   logic [7:0] life_reg;
   logic [15:0] temp_reg;
   logic [7:0] spare_reg;
   logic [7:0] spare_thr_reg;
   logic [127:0] ctr_reg [NUM_CTRS];
   logic [127:0] field [NUM_FIELDS];
   logic [NUM_CTRS-1:0] inc;
   logic [127:0] rd_kilo;
   logic [127:0] wr_kilo;
   logic [31:0] busy_cyc_reg;
   logic [5:0] busy_sec_reg;
   logic [31:0] awake_cyc_reg;
   logic [11:0] awake_sec_reg;
   logic [15:0] outstanding_reg;
   logic notice_seen_reg;
   logic busy;
   logic busy_sec_tick;
   logic busy_min_tick;
   logic awake_sec_tick;
   logic hour_tick;
   logic temp_over;
   logic spare_low;
   logic wr_counts;
   logic [3:0] fld_idx;
   logic [8:0] fld_ofs;
   logic [7:0] sel_byte;

   // Blocks of 2^shift bytes to 512-byte units; small blocks round up per command
   function automatic logic [31:0] to_units(input logic [15:0] blocks, input logic [3:0] shift);
      logic [3:0] dn;
      logic [31:0] wide;
      dn = 4'h0;
      wide = {16'h0000, blocks};
      if (shift >= UNIT_SHIFT)
         to_units = wide << (shift - UNIT_SHIFT);
      else
      begin
         dn = UNIT_SHIFT - shift;
         to_units = (wide + ((32'h00000001 << dn) - 32'h00000001)) >> dn;
      end
   endfunction : to_units

   // ----------------------------------------
   // Health conditions and warnings
   // ----------------------------------------
   assign temp_over = temp_kelvin_i > temp_threshold_i;
   assign spare_low = spare_pct_i < spare_threshold_i;

   // Bitmap follows the present state; bits 7:5 stay zero
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         crit_reg <= RESET_BYTE;
      else
      begin
         crit_reg <= RESET_BYTE;
         crit_reg[CRIT_SPARE] <= spare_low;
         crit_reg[CRIT_TEMP] <= temp_over;
         crit_reg[CRIT_DEGRADED] <= degraded_i;
         crit_reg[CRIT_READ_ONLY] <= read_only_i;
         crit_reg[CRIT_BACKUP] <= backup_failed_i;
      end
   end

   assign crit_warning_o = crit_reg;

   // Snapshot of the sensor values; spare is clamped to a valid percentage
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         temp_reg <= 16'h0000;
         spare_reg <= RESET_BYTE;
         spare_thr_reg <= RESET_BYTE;
      end
      else
      begin
         temp_reg <= temp_kelvin_i;
         spare_reg <= (spare_pct_i > SPARE_MAX) ? SPARE_MAX : spare_pct_i;
         spare_thr_reg <= spare_threshold_i;
      end
   end

   // Events fire once, in the cycle after a condition first appears, when its warning bit sets
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         temp_event_o <= 1'b0;
         spare_event_o <= 1'b0;
      end
      else
      begin
         temp_event_o <= temp_over && !crit_reg[CRIT_TEMP];
         spare_event_o <= spare_low && !crit_reg[CRIT_SPARE];
      end
   end

   // ----------------------------------------
   // Time base: busy minutes and awake hours
   // ----------------------------------------
   assign busy = outstanding_reg != 16'h0000;
   assign busy_sec_tick = busy && (busy_cyc_reg == 32'(SEC_CYCLES_P - 1));
   assign busy_min_tick = busy_sec_tick && (busy_sec_reg == SECS_PER_MIN - 6'h01);
   assign awake_sec_tick = !sleep_i && (awake_cyc_reg == 32'(SEC_CYCLES_P - 1));
   assign hour_tick = awake_sec_tick && (awake_sec_reg == SECS_PER_HOUR - 12'h001);

   // Commands outstanding between tail doorbell and completion posting
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         outstanding_reg <= 16'h0000;
      else if (io_submit_i && !io_complete_i)
         outstanding_reg <= outstanding_reg + 16'h0001;
      else if (io_complete_i && !io_submit_i && busy)
         outstanding_reg <= outstanding_reg - 16'h0001;
   end

   // Busy time only advances while work is outstanding
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         busy_cyc_reg <= 32'h00000000;
         busy_sec_reg <= 6'h00;
      end
      else if (busy)
      begin
         busy_cyc_reg <= busy_sec_tick ? 32'h00000000 : busy_cyc_reg + 32'h00000001;
         if (busy_sec_tick)
            busy_sec_reg <= busy_min_tick ? 6'h00 : busy_sec_reg + 6'h01;
      end
   end

   // Power-on time stops in low power states and resumes where it left off
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         awake_cyc_reg <= 32'h00000000;
         awake_sec_reg <= 12'h000;
      end
      else if (!sleep_i)
      begin
         awake_cyc_reg <= awake_sec_tick ? 32'h00000000 : awake_cyc_reg + 32'h00000001;
         if (awake_sec_tick)
            awake_sec_reg <= hour_tick ? 12'h000 : awake_sec_reg + 12'h001;
      end
   end

   // Life estimate sampled hourly, saturated to one byte
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         life_reg <= RESET_BYTE;
      else if (hour_tick)
         life_reg <= (life_estimate_i > {8'h00, LIFE_SAT_LIMIT}) ? LIFE_SAT
                     : life_estimate_i[7:0];
   end

   // ----------------------------------------
   // Shutdown notice tracking
   // ----------------------------------------
   // A notice arriving with power-up still counts: set wins over clear
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         notice_seen_reg <= 1'b0;
      else if (host_shutdown_notice_field_i != 2'b00)
         notice_seen_reg <= 1'b1;
      else if (power_up_i)
         notice_seen_reg <= 1'b0;
   end

   // ----------------------------------------
   // Event counters
   // ----------------------------------------
   assign wr_counts = wr_done_i && !wr_uncorr_i;

   always_comb
   begin
      inc = '0;
      inc[CTR_RD_CMD] = rd_done_i;
      inc[CTR_WR_CMD] = wr_counts;
      inc[CTR_BUSY_MIN] = busy_min_tick;
      inc[CTR_POWER_CYC] = power_up_i;
      inc[CTR_POWER_HRS] = hour_tick;
      inc[CTR_UNSAFE] = power_loss_i && !notice_seen_reg;
      inc[CTR_INTEGRITY] = integrity_err_i;
      inc[CTR_ERR_LOG] = err_log_entry_i;
   end

   // Every counter wraps at 128 bits
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CTRS; gi++)
      begin : g_ctr
         always_ff @(posedge sys_clk_i)
         begin
            if (sys_rst_i)
               ctr_reg[gi] <= 128'h0;
            else if (inc[gi])
               ctr_reg[gi] <= ctr_reg[gi] + 128'h1;
         end
         assign field[gi + 2] = ctr_reg[gi];
      end
   endgenerate

   // ----------------------------------------
   // Data unit accumulators
   // ----------------------------------------
   unit_kilo_counter u_rd_units (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .add_i (rd_done_i),
      .units_i (to_units(rd_blocks_i, lba_shift_i)),
      .kilo_o (rd_kilo)
   );

   // Write-uncorrectable moves no data and is kept out of the total
   unit_kilo_counter u_wr_units (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .add_i (wr_counts),
      .units_i (to_units(wr_blocks_i, lba_shift_i)),
      .kilo_o (wr_kilo)
   );

   assign field[0] = rd_kilo;
   assign field[1] = wr_kilo;

   // ----------------------------------------
   // Page read port
   // ----------------------------------------
   assign fld_ofs = page_addr_i - OFS_CTR_BASE;
   assign fld_idx = fld_ofs[7:4];

   // Byte selection; anything not listed reads zero
   always_comb
   begin
      sel_byte = RESET_BYTE;
      if (page_addr_i == OFS_CRIT)
         sel_byte = crit_reg;
      else if (page_addr_i == OFS_TEMP_LO)
         sel_byte = temp_reg[7:0];
      else if (page_addr_i == OFS_TEMP_HI)
         sel_byte = temp_reg[15:8];
      else if (page_addr_i == OFS_SPARE)
         sel_byte = spare_reg;
      else if (page_addr_i == OFS_SPARE_THR)
         sel_byte = spare_thr_reg;
      else if (page_addr_i == OFS_LIFE)
         sel_byte = life_reg;
      else if (page_addr_i >= OFS_CTR_BASE && page_addr_i <= OFS_CTR_END)
         sel_byte = field[fld_idx][{fld_ofs[3:0], 3'b000} +: 8];
   end

   // Data held between reads; valid marks the cycle after a request
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         page_data_o <= RESET_BYTE;
         page_valid_o <= 1'b0;
      end
      else
      begin
         page_valid_o <= page_rd_i;
         if (page_rd_i)
            page_data_o <= sel_byte;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_reserved_req;
      page_rd_i && (page_addr_i > OFS_CTR_END
                    || (page_addr_i > OFS_LIFE && page_addr_i < OFS_CTR_BASE));
   endsequence

   sequence s_hour_high;
      hour_tick && life_estimate_i > 16'h00FE;
   endsequence

   a_crit_temp: assert property (1'b1 |=> crit_reg[CRIT_TEMP] == $past(temp_over))
      else $error("temperature warning bit wrong");
   a_temp_event: assert property (temp_event_o |-> crit_reg[CRIT_TEMP]
                                  && !$past(crit_reg[CRIT_TEMP]))
      else $error("temperature event without new crossing");
   a_spare_event: assert property (spare_event_o |-> crit_reg[CRIT_SPARE]
                                   && !$past(crit_reg[CRIT_SPARE]))
      else $error("spare event without new crossing");
   a_life_saturate: assert property (s_hour_high |=> life_reg == 8'hFF)
      else $error("life used not saturated");
   a_life_hourly: assert property (!hour_tick |=> $stable(life_reg))
      else $error("life used changed off the hour");
   a_uncorr_skip: assert property (wr_done_i && wr_uncorr_i
                                   |=> $stable(ctr_reg[CTR_WR_CMD]))
      else $error("write-uncorrectable counted");
   a_rd_cmd_count: assert property (rd_done_i
                                    |=> ctr_reg[CTR_RD_CMD] == $past(ctr_reg[CTR_RD_CMD]) + 128'h1)
      else $error("read command not counted");
   a_busy_only: assert property (!busy |=> $stable(busy_cyc_reg)
                                 && $stable(ctr_reg[CTR_BUSY_MIN]))
      else $error("busy time advanced while idle");
   a_unsafe_count: assert property (power_loss_i && notice_seen_reg
                                    |=> $stable(ctr_reg[CTR_UNSAFE]))
      else $error("safe shutdown counted as unsafe");
   a_reserved_zero: assert property (s_reserved_req |=> page_valid_o
                                     && page_data_o == 8'h00)
      else $error("reserved byte not zero");

endmodule : health_log
`default_nettype wire

/* sim/host_model.sv */
// Host stand-in: submits one I/O command, holds it outstanding, then posts it.
// Assumes the bench raises start_i until busy_o rises; acts on falling edges.
`timescale 1ns/100ps
`default_nettype none
module host_model
(
   input wire logic sys_clk_i,
   input wire logic start_i,
   input wire logic [15:0] hold_i,
   output logic submit_o,
   output logic complete_o,
   output logic busy_o
);
   int left;
   // Idle until asked; no command is left half issued at time zero
   initial
   begin
      submit_o = 1'b0;
      complete_o = 1'b0;
      busy_o = 1'b0;
      left = 0;
   end
   // One command in flight; completion only after the full hold
   always @(negedge sys_clk_i)
   begin
      submit_o <= 1'b0;
      complete_o <= 1'b0;
      if (start_i && !busy_o)
      begin
         submit_o <= 1'b1;
         busy_o <= 1'b1;
         left <= int'(hold_i);
      end
      else if (busy_o && left == 0)
      begin
         complete_o <= 1'b1;
         busy_o <= 1'b0;
      end
      else if (busy_o)
         left <= left - 1;
   end
endmodule : host_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the statistics page: drives levels and pulses,
// reads fields back byte by byte. Assumes the package and host model are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import health_log_pkg::*;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] temp_k = 16'h0000, temp_thr = 16'hFFFF, life = 16'h0000, blocks = 16'h0000;
   logic [7:0] spare = 8'h00, spare_thr = 8'h00;
   logic deg = 1'b0, ro = 1'b0, bkp = 1'b0, sleep = 1'b1, rd_done = 1'b0, wr_done = 1'b0;
   logic unc = 1'b0, page_rd = 1'b0, start = 1'b0;
   logic [3:0] shift = 4'h9, pls = 4'h0;
   logic [1:0] notice = 2'h0;
   logic [8:0] page_addr = 9'h000;
   logic [7:0] page_data, crit;
   logic page_valid, temp_ev, spare_ev, sub, cpl, host_busy;
   int tev = 0, sev = 0, failures = 0, num_checks = 0;
   // Short second keeps minute and hour runs within the cycle budget
   localparam int SECS = 4;

   initial
   begin
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   health_log #(.SEC_CYCLES_P(SECS)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .temp_kelvin_i(temp_k), .temp_threshold_i(temp_thr), .spare_pct_i(spare),
      .spare_threshold_i(spare_thr), .life_estimate_i(life), .degraded_i(deg),
      .read_only_i(ro), .backup_failed_i(bkp), .sleep_i(sleep), .rd_done_i(rd_done),
      .rd_blocks_i(blocks), .wr_done_i(wr_done), .wr_blocks_i(blocks), .wr_uncorr_i(unc),
      .lba_shift_i(shift), .io_submit_i(sub), .io_complete_i(cpl), .power_up_i(pls[0]),
      .power_loss_i(pls[1]), .host_shutdown_notice_field_i(notice),
      .integrity_err_i(pls[2]), .err_log_entry_i(pls[3]), .page_rd_i(page_rd),
      .page_addr_i(page_addr), .page_data_o(page_data), .page_valid_o(page_valid),
      .temp_event_o(temp_ev), .spare_event_o(spare_ev), .crit_warning_o(crit));

   host_model host (.sys_clk_i(sys_clk_i), .start_i(start), .hold_i(16'h00FA),
      .submit_o(sub), .complete_o(cpl), .busy_o(host_busy));

   // Event pulses are counted so a stuck or repeated pulse shows up
   always @(posedge sys_clk_i)
   begin
      tev <= tev + int'(temp_ev === 1'b1);
      sev <= sev + int'(spare_ev === 1'b1);
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input string name, input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   // Request is held across one rising edge, answer read a cycle later
   task automatic fld(input string name, input logic [8:0] base, input int n,
      input logic [127:0] exp);
      logic [127:0] v;
      v = '0;
      for (int i = 0; i < n; i++)
      begin
         @(negedge sys_clk_i);
         page_rd = 1'b1;
         page_addr = base + 9'(i);
         @(negedge sys_clk_i);
         page_rd = 1'b0;
         v[8*i +: 8] = page_data;
         chk("page_valid", 128'(page_valid), 128'h1);
      end
      chk(name, v, exp);
   endtask : fld

   // One completed command; settle time covers unit retirement
   task automatic cmd(input logic wr, input logic u, input logic [15:0] n);
      @(negedge sys_clk_i);
      rd_done = ~wr;
      wr_done = wr;
      unc = u;
      blocks = n;
      @(negedge sys_clk_i);
      rd_done = 1'b0;
      wr_done = 1'b0;
      unc = 1'b0;
      repeat (10) @(negedge sys_clk_i);
   endtask : cmd

   task automatic pulse(input int k);
      @(negedge sys_clk_i);
      pls[k] = 1'b1;
      @(negedge sys_clk_i);
      pls[k] = 1'b0;
   endtask : pulse

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (16) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      // Warning levels and threshold crossings
      temp_thr = 16'h0150;
      spare_thr = 8'h14;
      temp_k = 16'h0155;
      spare = 8'h0A;
      deg = 1'b1;
      ro = 1'b1;
      bkp = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      chk("crit_warning", 128'(crit), 128'h1F);
      fld("crit byte", 9'h000, 1, 128'h1F);
      fld("temperature", 9'h001, 2, 128'h0155);
      chk("temp events", 128'(tev), 128'h1);
      fld("spare", 9'h003, 1, 128'h0A);
      fld("spare threshold", 9'h004, 1, 128'h14);
      chk("spare events", 128'(sev), 128'h1);
      spare = 8'hC8;
      temp_k = 16'h0140;
      deg = 1'b0;
      ro = 1'b0;
      bkp = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      fld("spare clamp", 9'h003, 1, 128'h64);
      chk("crit clear", 128'(crit), 128'h00);
      // Data units, rounded up in thousands, across block sizes
      cmd(1'b0, 1'b0, 16'h0001);
      fld("read units", 9'h020, 16, 128'h1);
      cmd(1'b0, 1'b0, 16'h03E7);
      fld("read units", 9'h020, 16, 128'h1);
      cmd(1'b0, 1'b0, 16'h0001);
      fld("read units", 9'h020, 16, 128'h2);
      shift = 4'hC;
      cmd(1'b0, 1'b0, 16'h007D);
      fld("read units", 9'h020, 16, 128'h3);
      fld("read cmds", 9'h040, 16, 128'h4);
      shift = 4'h9;
      cmd(1'b1, 1'b0, 16'h07D0);
      cmd(1'b1, 1'b1, 16'h01F4);
      fld("write units", 9'h030, 16, 128'h2);
      shift = 4'h8;
      cmd(1'b1, 1'b0, 16'h0001);
      fld("write units", 9'h030, 16, 128'h3);
      fld("write cmds", 9'h050, 16, 128'h2);
      // Power events, shutdown notice and error tallies
      pulse(0);
      pulse(1);
      notice = 2'h1;
      pulse(1);
      notice = 2'h0;
      pulse(0);
      pulse(1);
      pulse(2);
      pulse(2);
      for (int i = 0; i < 3; i++)
         pulse(3);
      repeat (2) @(negedge sys_clk_i);
      fld("power cycles", 9'h070, 16, 128'h2);
      fld("unsafe", 9'h090, 16, 128'h2);
      fld("integrity", 9'h0A0, 16, 128'h2);
      fld("error entries", 9'h0B0, 16, 128'h3);
      // One command outstanding a little over a minute
      start = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      start = 1'b0;
      for (int i = 0; i < 400 && host_busy; i++)
         @(negedge sys_clk_i);
      if (host_busy)
      begin
         failures++;
         wrap_up();
      end
      repeat (2) @(negedge sys_clk_i);
      fld("busy minutes", 9'h060, 16, 128'h1);
      // Sleep time is excluded, then two awake hours with saturation
      life = 16'h012C;
      repeat (15000) @(negedge sys_clk_i);
      fld("hours asleep", 9'h080, 16, 128'h0);
      fld("life asleep", 9'h005, 1, 128'h00);
      sleep = 1'b0;
      repeat (14410) @(negedge sys_clk_i);
      fld("hours", 9'h080, 16, 128'h1);
      fld("life saturated", 9'h005, 1, 128'hFF);
      life = 16'h00FE;
      repeat (14400) @(negedge sys_clk_i);
      fld("hours", 9'h080, 16, 128'h2);
      fld("life limit", 9'h005, 1, 128'hFE);
      // Reserved bytes stay zero with every field busy
      for (int a = 6; a < 512; a++)
         if (a < 32 || a > 191)
            fld("reserved", 9'(a), 1, 128'h0);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
